// ### dv/chain_driver_model.sv
// listen-only model of the serial driver chain
// assumes the sequencer drives clock, data and frame select
`timescale 1ns/1ps
module chain_driver_model (
  input wire logic chain_sclk,
  input wire logic chain_sdo,
  input wire logic chain_csn
);
  logic bits_q[$];
  int frames = 0;
  // chain shift registers take data on the rising clock
  always @(posedge chain_sclk) begin
    if (!chain_csn) bits_q.push_back(chain_sdo);
  end
  always @(posedge chain_csn) begin
    frames++;
  end
endmodule // chain_driver_model

// ### dv/chain_seq_properties.sv
// port checker for the driver chain datagram sequencer
// assumes it is bound onto the sequencer top module, one clock domain
`timescale 1ns/1ps
module chain_seq_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic chain_sclk,
  input wire logic chain_sdo,
  input wire logic chain_csn
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // serial clock high time
  logic [7:0] hi_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || !chain_sclk) hi_cnt_r <= 8'h00;
    else hi_cnt_r <= hi_cnt_r + 8'h01;
  end
  // ==========================================
  // properties
  property p_sclk_idle;
    chain_csn |-> !chain_sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock active outside a frame");
  property p_sdo_steady;
    chain_sclk |-> $stable(chain_sdo);
  endproperty
  a_sdo_steady: assert property (p_sdo_steady)
    else $error("serial data moved while clock high");
  property p_high_len;
    $fell(chain_sclk) |-> hi_cnt_r == 8'(chain_seq_pkg::HALF_CYC);
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("serial clock high phase has wrong length");
  property p_csn_rise;
    $rose(chain_csn) |-> !chain_sclk;
  endproperty
  a_csn_rise: assert property (p_csn_rise)
    else $error("frame ended with serial clock high");
  property p_frame_start;
    $fell(chain_csn) |-> !chain_sclk ##1 !chain_sclk;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame opened without a low clock phase");
  property p_ar_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_resp: assert property (p_ar_resp)
    else $error("read data late after address taken");
  property p_ar_pulse;
    s_axi_arready |=> !s_axi_arready;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse)
    else $error("read address ready held too long");
  property p_unmapped_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr inside {[8'h14:8'h7F]}
      |=> s_axi_rvalid && s_axi_rresp == chain_seq_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped read not refused");
  c_frame: cover property ($fell(chain_csn));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == chain_seq_pkg::RESP_SLVERR);
endmodule // chain_seq_properties

bind driver_chain_datagram_sequencer chain_seq_properties u_chain_seq_properties (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .chain_sclk(chain_sclk), .chain_sdo(chain_sdo), .chain_csn(chain_csn)
);

// ### dv/driver_chain_datagram_sequencer_tb.sv
// self-checking bench for the driver chain datagram sequencer
// assumes the sequencer, its checker and the chain model are compiled first
`timescale 1ns/1ps
module driver_chain_datagram_sequencer_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, motion_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sclk, sdo, csn;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [5:0] cfg [24];
  logic [17:0] sig [3];
  logic exp_q[$];
  int failures = 0;
  int tests_run = 0;
  always #2.5 aclk = ~aclk;
  driver_chain_datagram_sequencer u_driver_chain_datagram_sequencer (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .motion_req(motion_req), .chain_sclk(sclk), .chain_sdo(sdo), .chain_csn(csn)
  );
  chain_driver_model u_chain_driver_model (.chain_sclk(sclk), .chain_sdo(sdo), .chain_csn(csn));
  // ==========================================
  // checking and bus tasks
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic timeout();
    failures++;
    tally_and_finish();
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 200) timeout();
    bready <= 1'b0;
    check32({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 200) timeout();
    rready <= 1'b0;
    check32(rdata & m, e);
    check32({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic wait_csn(input logic v);
    int n;
    for (n = 0; n < 20000 && csn !== v; n++) @(posedge aclk);
    if (csn !== v) timeout();
  endtask
  // wait out any frames started by register writes, then forget them
  task automatic settle();
    int n, q;
    q = 0;
    for (n = 0; n < 40000 && q < 300; n++) begin
      @(posedge aclk);
      q = csn ? q + 1 : 0;
    end
    if (q < 300) timeout();
    u_chain_driver_model.bits_q.delete();
  endtask
  function automatic logic exp_bit(input logic [4:0] c, input logic [17:0] s);
    if (c < chain_seq_pkg::CODE_ZERO) return s[c[3:0]];
    case (c)
      chain_seq_pkg::CODE_ZERO: return 1'b0;
      chain_seq_pkg::CODE_ONE: return 1'b1;
      chain_seq_pkg::CODE_DIR: return s[16];
      chain_seq_pkg::CODE_STEP: return s[17];
      default: return 1'b0;
    endcase
  endfunction
  task automatic check_frame(input int last);
    int i, m;
    m = 0;
    exp_q.delete();
    for (i = 0; i < 24; i++) begin
      exp_q.push_back(exp_bit(cfg[i][4:0], sig[m]));
      if (cfg[i][5]) begin
        if (m == last) break;
        m++;
      end
    end
    check32(32'(u_chain_driver_model.bits_q.size()), 32'(exp_q.size()));
    for (i = 0; i < exp_q.size() && i < u_chain_driver_model.bits_q.size(); i++) begin
      check32({31'h0, u_chain_driver_model.bits_q[i]}, {31'h0, exp_q[i]});
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    int i;
    sig[0] = 18'h2A5C3;
    sig[1] = 18'h15A3C;
    sig[2] = 18'h30F0F;
    for (i = 0; i < 20; i++) cfg[i] = {i == 19, i[4:0]};
    cfg[20] = 6'h14;
    cfg[21] = 6'h1F;
    cfg[22] = 6'h31;
    cfg[23] = 6'h32;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(chain_seq_pkg::CTRL_OFS, 32'h131, 32'h20, 2'h0);
    rd_chk(chain_seq_pkg::STAT_OFS, 32'h3, 32'h0, 2'h0);
    rd_chk(8'h94, 32'h800, 32'h800, 2'h0);
    repeat (200) @(posedge aclk);
    check32({31'h0, csn}, 32'h1);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0, chain_seq_pkg::RESP_SLVERR);
    axi_write(8'h44, 32'h1, chain_seq_pkg::RESP_SLVERR);
    $display("test reset and map done");
    for (i = 0; i < 12; i++) begin
      axi_write(8'h80 + 8'(4 * i), {20'h0, cfg[2*i+1], cfg[2*i]}, 2'h0);
    end
    for (i = 0; i < 3; i++) axi_write(8'h08 + 8'(4 * i), {14'h0, sig[i]}, 2'h0);
    settle();
    axi_write(chain_seq_pkg::CTRL_OFS, 32'h21, 2'h0);
    wait_csn(1'b0);
    axi_write(chain_seq_pkg::SIGA_OFS, 32'h0, 2'h0);
    rd_chk(chain_seq_pkg::RAM_BASE, 32'hFFF, {20'h0, cfg[1], cfg[0]}, 2'h0);
    wait_csn(1'b1);
    check_frame(2);
    check_frame(2);
    $display("test full chain frame done");
    axi_write(chain_seq_pkg::CTRL_OFS, 32'h00, 2'h0);
    axi_write(chain_seq_pkg::SIGA_OFS, 32'h3C3A5, 2'h0);
    sig[0] = 18'h3C3A5;
    rd_chk(chain_seq_pkg::SIGA_OFS, 32'h3FFFF, {14'h0, sig[0]}, 2'h0);
    axi_write(chain_seq_pkg::RAM_BASE, {20'h0, 6'h11, 6'h11}, 2'h0);
    cfg[0] = 6'h11;
    cfg[1] = 6'h11;
    settle();
    motion_req <= 1'b1;
    repeat (4) @(posedge aclk);
    motion_req <= 1'b0;
    wait_csn(1'b0);
    wait_csn(1'b1);
    check_frame(0);
    rd_chk(chain_seq_pkg::STAT_OFS, 32'h3, 32'h0, 2'h0);
    $display("test short chain frame done");
    axi_write(chain_seq_pkg::CTRL_OFS, 32'h100, 2'h0);
    settle();
    axi_write(8'h44, 32'h0, chain_seq_pkg::RESP_SLVERR);
    repeat (20) @(posedge aclk);
    check32({31'h0, csn}, 32'h1);
    axi_write(chain_seq_pkg::SIGB_OFS, {14'h0, sig[1]}, 2'h0);
    wait_csn(1'b0);
    wait_csn(1'b1);
    check_frame(0);
    $display("test auto send frame done");
    tally_and_finish();
  end
endmodule // driver_chain_datagram_sequencer_tb

// ### src/chain_seq_pkg.sv
// constants and carrier types of the driver chain datagram sequencer
// assumes a 200 MHz system clock and an AXI4-Lite register bus
package chain_seq_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SCLK_NS = 400;
  localparam int unsigned HALF_CYC = (SCLK_NS * CLK_MHZ) / 2000;
  // register byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] SIGA_OFS = 8'h08;
  localparam logic [7:0] SIGB_OFS = 8'h0C;
  localparam logic [7:0] SIGC_OFS = 8'h10;
  localparam logic [7:0] RAM_BASE = 8'h80;
  localparam int unsigned CTRL_REQ_BIT = 0;
  localparam int unsigned CTRL_LAST_LSB = 4;
  localparam int unsigned CTRL_AUTO_BIT = 8;
  localparam logic [1:0] LAST_RST = 2'h2;
  localparam logic AUTO_RST = 1'b0;
  localparam logic [17:0] SIG_RST = 18'h00000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // signal select codes
  localparam logic [4:0] CODE_A_POL = 5'h06;
  localparam logic [4:0] CODE_A_FD = 5'h07;
  localparam logic [4:0] CODE_B_POL = 5'h0E;
  localparam logic [4:0] CODE_B_FD = 5'h0F;
  localparam logic [4:0] CODE_ZERO = 5'h10;
  localparam logic [4:0] CODE_ONE = 5'h11;
  localparam logic [4:0] CODE_DIR = 5'h12;
  localparam logic [4:0] CODE_STEP = 5'h13;
  // per motor signal set
  typedef struct packed {
    logic step;
    logic direction;
    logic coil_b_fast_decay;
    logic coil_b_polarity;
    logic [5:0] coil_b_current;
    logic coil_a_fast_decay;
    logic coil_a_polarity;
    logic [5:0] coil_a_current;
  } motor_sig_t;
  typedef struct packed {
    logic next_motor_flag;
    logic [4:0] code;
  } cfg_entry_t;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_LOW, ST_HIGH} seq_state_t;
endpackage

// ### src/driver_chain_datagram_sequencer.sv
// driver chain datagram sequencer: config RAM, AXI4-Lite slave, serial framer
// assumes one 200 MHz clock, synchronous active-low reset, AXI4-Lite master
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module driver_chain_datagram_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic motion_req,
  output logic chain_sclk,
  output logic chain_sdo,
  output logic chain_csn
);
  // ==========================================================
  // configuration RAM
  // ==========================================================
  chain_seq_pkg::cfg_entry_t ram_r [0:63];
  // ==========================================================
  // registers
  // ==========================================================
  logic [1:0] last_driver_index_r;
  logic auto_send_r;
  logic req_pend_r;
  chain_seq_pkg::motor_sig_t [2:0] sig_r;
  chain_seq_pkg::motor_sig_t [2:0] snap_r;
  chain_seq_pkg::seq_state_t state_r;
  logic [5:0] ptr_r;
  logic [1:0] motor_driver_address_r;
  logic [7:0] div_r;
  logic busy_r;
  logic mreq_s1_r;
  logic mreq_s2_r;
  logic mreq_d_r;
  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  logic [7:0] awaddr_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;
  logic do_write;
  logic wr_ram;
  logic wr_reg_ok;
  logic [5:0] wr_idx;
  // ready pulses for one cycle; no new transfer while the response waits
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_ram = awaddr_r[7];
  assign wr_idx = awaddr_r[6:1];
  always_comb begin
    case (awaddr_r)
      chain_seq_pkg::CTRL_OFS,
      chain_seq_pkg::SIGA_OFS,
      chain_seq_pkg::SIGB_OFS,
      chain_seq_pkg::SIGC_OFS: wr_reg_ok = 1'b1;
      default: wr_reg_ok = wr_ram;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= chain_seq_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_reg_ok ? chain_seq_pkg::RESP_OKAY : chain_seq_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  logic [31:0] rd_val;
  logic rd_ok;
  logic [5:0] rd_idx;
  // read data is captured as the address is taken
  assign rd_idx = s_axi_araddr[6:1];
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7]) begin
      // even entry in bits 5:0, odd in 11:6
      rd_val = {20'h00000, ram_r[{rd_idx[5:1], 1'b1}], ram_r[{rd_idx[5:1], 1'b0}]};
    end else begin
      case ({s_axi_araddr[7:2], 2'b00})
        chain_seq_pkg::CTRL_OFS: rd_val = {23'h000000, auto_send_r, 2'h0,
                                           last_driver_index_r, 3'h0, req_pend_r};
        chain_seq_pkg::STAT_OFS: rd_val = {24'h000000, ptr_r, motor_driver_address_r[0],
                                           busy_r};
        chain_seq_pkg::SIGA_OFS: rd_val = {14'h0000, sig_r[0]};
        chain_seq_pkg::SIGB_OFS: rd_val = {14'h0000, sig_r[1]};
        chain_seq_pkg::SIGC_OFS: rd_val = {14'h0000, sig_r[2]};
        default: rd_ok = 1'b0;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= chain_seq_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? chain_seq_pkg::RESP_OKAY : chain_seq_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // RAM write and default layout
  // ==========================================================
  function automatic chain_seq_pkg::cfg_entry_t dflt(input int unsigned i);
    logic [3:0] p;
    chain_seq_pkg::cfg_entry_t e;
    p = 4'(i % 12);
    e.next_motor_flag = (p == 4'hB) && (i < 36);
    case (p)
      4'h0, 4'h6: e.code = chain_seq_pkg::CODE_ONE;
      4'h5: e.code = chain_seq_pkg::CODE_A_POL;
      4'hB: e.code = chain_seq_pkg::CODE_B_POL;
      4'h1, 4'h2, 4'h3, 4'h4: e.code = 5'(6 - p);
      default: e.code = 5'(20 - p);
    endcase
    if (i >= 36) e = '{next_motor_flag: 1'b0, code: chain_seq_pkg::CODE_ZERO};
    return e;
  endfunction
  // reset reloads the default layout every time, not only at power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 64; i++) begin
        ram_r[i] <= dflt(i);
      end
    end else if (do_write && wr_ram) begin
      // byte lane 0 feeds even entry, lane 1 the odd one
      if (wstrb_r[0]) ram_r[{wr_idx[5:1], 1'b0}] <= wdata_r[5:0];
      if (wstrb_r[1]) ram_r[{wr_idx[5:1], 1'b1}] <= wdata_r[11:6];
    end
  end
  // ==========================================================
  // control and motor signal registers
  // ==========================================================
  logic start_go;
  assign start_go = state_r == chain_seq_pkg::ST_IDLE && req_pend_r;
  // signal registers take all 18 bits regardless of byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_driver_index_r <= chain_seq_pkg::LAST_RST;
      auto_send_r <= chain_seq_pkg::AUTO_RST;
      for (int m = 0; m < 3; m++) begin
        sig_r[m] <= chain_seq_pkg::SIG_RST;
      end
    end else if (do_write && !wr_ram) begin
      case (awaddr_r)
        chain_seq_pkg::CTRL_OFS: begin
          if (wstrb_r[0]) last_driver_index_r <= wdata_r[chain_seq_pkg::CTRL_LAST_LSB +: 2];
          if (wstrb_r[1]) auto_send_r <= wdata_r[chain_seq_pkg::CTRL_AUTO_BIT];
        end
        chain_seq_pkg::SIGA_OFS: sig_r[0] <= wdata_r[17:0];
        chain_seq_pkg::SIGB_OFS: sig_r[1] <= wdata_r[17:0];
        chain_seq_pkg::SIGC_OFS: sig_r[2] <= wdata_r[17:0];
        default: ;
      endcase
    end
  end
  // motion request pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mreq_s1_r <= 1'b0;
      mreq_s2_r <= 1'b0;
      mreq_d_r <= 1'b0;
    end else begin
      mreq_s1_r <= motion_req;
      mreq_s2_r <= mreq_s1_r;
      mreq_d_r <= mreq_s2_r;
    end
  end
  // request sources: CTRL request bit, auto send on a signal register write, pin edge
  logic ctrl_req;
  logic auto_req;
  logic pin_req;
  logic req_set;
  assign ctrl_req = do_write && !wr_ram && awaddr_r == chain_seq_pkg::CTRL_OFS && wstrb_r[0]
                    && wdata_r[chain_seq_pkg::CTRL_REQ_BIT];
  // a refused write has no effect, so it requests nothing either
  assign auto_req = do_write && !wr_ram && wr_reg_ok && auto_send_r
                    && awaddr_r != chain_seq_pkg::CTRL_OFS;
  assign pin_req = mreq_s2_r && !mreq_d_r;
  // pending request: set wins over the clear at start
  assign req_set = ctrl_req || auto_req || pin_req;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_pend_r <= 1'b0;
    end else if (req_set) begin
      req_pend_r <= 1'b1;
    end else if (start_go) begin
      req_pend_r <= 1'b0;
    end
  end
  // ==========================================================
  // datagram sequencer
  // ==========================================================
  chain_seq_pkg::cfg_entry_t cur;
  chain_seq_pkg::motor_sig_t ms;
  logic bit_val;
  assign cur = ram_r[ptr_r];
  assign ms = snap_r[motor_driver_address_r];
  always_comb begin
    bit_val = 1'b0;
    if (cur.code[4:3] == 2'b00) begin
      case (cur.code[2:0])
        3'h6: bit_val = ms.coil_a_polarity;
        3'h7: bit_val = ms.coil_a_fast_decay;
        default: bit_val = ms.coil_a_current[cur.code[2:0]];
      endcase
    end else if (cur.code[4:3] == 2'b01) begin
      case (cur.code[2:0])
        3'h6: bit_val = ms.coil_b_polarity;
        3'h7: bit_val = ms.coil_b_fast_decay;
        default: bit_val = ms.coil_b_current[cur.code[2:0]];
      endcase
    end else begin
      case (cur.code)
        chain_seq_pkg::CODE_ZERO: bit_val = 1'b0;
        chain_seq_pkg::CODE_ONE: bit_val = 1'b1;
        chain_seq_pkg::CODE_DIR: bit_val = ms.direction;
        chain_seq_pkg::CODE_STEP: bit_val = ms.step;
        default: bit_val = 1'b0;
      endcase
    end
  end
  // each bit: one load cycle, then HALF_CYC low and HALF_CYC high
  logic div_end;
  assign div_end = div_r == 8'(chain_seq_pkg::HALF_CYC - 1);
  // a last index of 3 still stops at the third driver, never past snap_r
  logic more_motors;
  assign more_motors = motor_driver_address_r < last_driver_index_r
                       && motor_driver_address_r != 2'h2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= chain_seq_pkg::ST_IDLE;
      ptr_r <= 6'h00;
      motor_driver_address_r <= 2'h0;
      div_r <= 8'h00;
      busy_r <= 1'b0;
      chain_sclk <= 1'b0;
      chain_sdo <= 1'b0;
      chain_csn <= 1'b1;
      for (int m = 0; m < 3; m++) begin
        snap_r[m] <= chain_seq_pkg::SIG_RST;
      end
    end else begin
      case (state_r)
        chain_seq_pkg::ST_IDLE: begin
          // snapshot so one frame sees one consistent signal set
          if (start_go) begin
            snap_r <= sig_r;
            ptr_r <= 6'h00;
            motor_driver_address_r <= 2'h0;
            busy_r <= 1'b1;
            chain_csn <= 1'b0;
            state_r <= chain_seq_pkg::ST_LOAD;
          end
        end
        chain_seq_pkg::ST_LOAD: begin
          chain_sdo <= bit_val;
          div_r <= 8'h00;
          state_r <= chain_seq_pkg::ST_LOW;
        end
        chain_seq_pkg::ST_LOW: begin
          div_r <= div_r + 8'h01;
          if (div_end) begin
            div_r <= 8'h00;
            chain_sclk <= 1'b1;
            state_r <= chain_seq_pkg::ST_HIGH;
          end
        end
        chain_seq_pkg::ST_HIGH: begin
          div_r <= div_r + 8'h01;
          if (div_end) begin
            chain_sclk <= 1'b0;
            ptr_r <= ptr_r + 6'h01;
            state_r <= chain_seq_pkg::ST_LOAD;
            // flag closes this driver's bits, or the frame at the last one
            if (cur.next_motor_flag) begin
              if (more_motors) begin
                motor_driver_address_r <= motor_driver_address_r + 2'h1;
              end else begin
                motor_driver_address_r <= 2'h0;
                ptr_r <= 6'h00;
                busy_r <= 1'b0;
                chain_csn <= 1'b1;
                state_r <= chain_seq_pkg::ST_IDLE;
              end
            end
          end
        end
        default: state_r <= chain_seq_pkg::ST_IDLE;
      endcase
    end
  end
endmodule // driver_chain_datagram_sequencer
